// ==== design/dped_pkg.sv ====
// Constants, field positions and state type of the directory-pointer entry decoder
package dped_pkg;
	// Entry fields
	localparam int EXEC_DISABLE_POS = 63;
	localparam int RSV_TOP_POS      = 51;
	localparam int ADDR_LSB         = 12;
	localparam int EXT_ACCESS_POS   = 10;
	localparam int RSV_LOW_POS      = 7;
	localparam int ACCESSED_POS     = 5;
	localparam int USER_SUP_POS     = 2;
	localparam int WRITE_PERMIT_POS = 1;
	localparam int PRESENT_POS      = 0;
	localparam int ENTRY_W          = 64;
	localparam int BASE_W           = 52;

	// Address widths
	localparam logic [6:0] ADDR_W_CLIENT = 7'h27;
	localparam logic [6:0] ADDR_W_SERVER = 7'h2e;

	// Write-back memory type code
	localparam logic [2:0] MEMTYPE_WB = 3'h6;

	// Register byte offsets
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_STATUS  = 5'h04;
	localparam logic [4:0] OFS_BASE_LO = 5'h08;
	localparam logic [4:0] OFS_BASE_HI = 5'h0c;
	localparam logic [4:0] OFS_ENT_LO  = 5'h10;
	localparam logic [4:0] OFS_ENT_HI  = 5'h14;

	// Control bits
	localparam int CTRL_NO_EXEC = 0;
	localparam int CTRL_NESTED  = 1;
	localparam int CTRL_SUP_WP  = 2;
	localparam int CTRL_EXT_ACC = 3;
	localparam int CTRL_SERVER = 4;
	localparam int CTRL_W      = 5;
	localparam logic [4:0] CTRL_RST = 5'h10;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHECK,
		ST_WB,
		ST_DONE
	} dped_state_e;
endpackage : dped_pkg

// ==== design/dped_dec_if.sv ====
// Signals between the walker control and the entry checker
`timescale 1ns/10ps
`default_nettype none
interface dped_dec_if;
	logic [63:0] entry;
	logic        no_exec_enable;
	logic        nested_translation_enable;
	logic        supervisor_write_protect_enable;
	logic        extended_access_flag_enable;
	logic        server;
	logic        sup;
	logic        np;
	logic        rsv;
	logic        fault;
	logic [51:0] base;
	logic        gpa;
	logic [2:0]  perm;
	logic        upd;
	logic [63:0] wb_entry;

	modport chk (
		input  entry, no_exec_enable, nested_translation_enable,
			supervisor_write_protect_enable, extended_access_flag_enable, server, sup,
		output np, rsv, fault, base, gpa, perm, upd, wb_entry
	);
	modport ctl (
		output entry, no_exec_enable, nested_translation_enable,
			supervisor_write_protect_enable, extended_access_flag_enable, server, sup,
		input  np, rsv, fault, base, gpa, perm, upd, wb_entry
	);
endinterface : dped_dec_if
`default_nettype wire

// ==== design/dped_entry_check.sv ====
// Combinational decode and check of one directory-pointer entry
`timescale 1ns/10ps
`default_nettype none
module dped_entry_check (
	dped_dec_if.chk d
);
	logic [6:0]  host_address_width;
	logic [63:0] rsv_m;
	logic [63:0] adr_m;

	assign host_address_width = d.server ? dped_pkg::ADDR_W_SERVER : dped_pkg::ADDR_W_CLIENT;

	for (genvar i = 0; i < 64; i++) begin : g_bit
		assign rsv_m[i] = (i == dped_pkg::RSV_LOW_POS) ||
			((i <= dped_pkg::RSV_TOP_POS) && (7'(i) >= host_address_width));
		assign adr_m[i] = (i >= dped_pkg::ADDR_LSB) && (7'(i) < host_address_width);
	end

	always_comb begin
		d.np    = !d.entry[dped_pkg::PRESENT_POS];
		d.rsv   = |(d.entry & rsv_m);
		d.fault = d.np || d.rsv;
		// base extraction; ignored bits fall outside every mask
		d.base  = d.entry[51:0] & adr_m[51:0];
		d.gpa   = d.nested_translation_enable && !d.fault;
		d.perm[2] = !(d.no_exec_enable && d.entry[dped_pkg::EXEC_DISABLE_POS]);
		// write permission, checked as user-level in every case
		d.perm[1] = d.entry[dped_pkg::WRITE_PERMIT_POS] &&
			!(d.sup && d.supervisor_write_protect_enable &&
			!d.entry[dped_pkg::WRITE_PERMIT_POS]);
		// user permission applies to all requests
		d.perm[0] = d.entry[dped_pkg::USER_SUP_POS];
		d.wb_entry = d.entry;
		d.wb_entry[dped_pkg::ACCESSED_POS] = 1'b1;
		// extended access only under its enable
		if (d.extended_access_flag_enable) begin
			d.wb_entry[dped_pkg::EXT_ACCESS_POS] = 1'b1;
		end
		d.upd = !d.fault && (!d.entry[dped_pkg::ACCESSED_POS] ||
			(d.extended_access_flag_enable && !d.entry[dped_pkg::EXT_ACCESS_POS]));
	end
endmodule : dped_entry_check
`default_nettype wire

// ==== design/dped_top.sv ====
// Directory-pointer entry decoder: walk control, write-back and register slave
`timescale 1ns/10ps
`default_nettype none
module dped_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	// Entry from walker
	input  wire logic        req_valid,
	output var  logic        req_ready,
	input  wire logic [63:0] req_entry,
	input  wire logic        req_sup,
	// Decode result
	output var  logic        rsp_valid,
	output var  logic        rsp_fault,
	output var  logic [51:0] rsp_base,
	output var  logic        rsp_gpa,
	output var  logic [2:0]  rsp_perm,
	output var  logic [2:0]  rsp_memtype,
	// Entry write-back
	output var  logic        wb_valid,
	input  wire logic        wb_ready,
	output var  logic [63:0] wb_entry
);
	dped_pkg::dped_state_e st_r;
	logic [63:0]  ent_r;
	logic         sup_r;
	logic [4:0]   ctrl_r;
	logic [3:0]   last_r;
	logic [15:0]  walks_r;
	logic         acc;
	logic [31:0]  rd_nxt;

	dped_dec_if d ();

	assign d.entry  = ent_r;
	assign d.sup    = sup_r;
	assign d.no_exec_enable                  = ctrl_r[dped_pkg::CTRL_NO_EXEC];
	assign d.nested_translation_enable       = ctrl_r[dped_pkg::CTRL_NESTED];
	assign d.supervisor_write_protect_enable = ctrl_r[dped_pkg::CTRL_SUP_WP];
	assign d.extended_access_flag_enable     = ctrl_r[dped_pkg::CTRL_EXT_ACC];
	assign d.server                          = ctrl_r[dped_pkg::CTRL_SERVER];

	dped_entry_check u_chk (
		.d (d.chk)
	);

	// Walk sequence
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= dped_pkg::ST_IDLE;
		end else begin
			case (st_r)
				dped_pkg::ST_IDLE: begin
					if (req_valid) begin
						st_r <= dped_pkg::ST_CHECK;
					end
				end
				dped_pkg::ST_CHECK: begin
					st_r <= d.upd ? dped_pkg::ST_WB : dped_pkg::ST_DONE;
				end
				dped_pkg::ST_WB: begin
					if (wb_ready) begin
						st_r <= dped_pkg::ST_DONE;
					end
				end
				dped_pkg::ST_DONE: begin
					st_r <= dped_pkg::ST_IDLE;
				end
				default: begin
					st_r <= dped_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Request capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ent_r     <= 64'h0;
			sup_r     <= 1'b0;
			req_ready <= 1'b1;
		end else begin
			if (st_r == dped_pkg::ST_IDLE && req_valid) begin
				ent_r     <= req_entry;
				sup_r     <= req_sup;
				req_ready <= 1'b0;
			end else if (st_r == dped_pkg::ST_DONE) begin
				req_ready <= 1'b1;
			end
		end
	end

	// Results held until the next walk is checked
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_fault   <= 1'b0;
			rsp_base    <= 52'h0;
			rsp_gpa     <= 1'b0;
			rsp_perm    <= 3'h0;
			rsp_memtype <= dped_pkg::MEMTYPE_WB;
			last_r      <= 4'h0;
		end else if (st_r == dped_pkg::ST_CHECK) begin
			rsp_fault   <= d.fault;
			rsp_base    <= d.fault ? 52'h0 : d.base;
			rsp_gpa     <= d.gpa;
			rsp_perm    <= d.fault ? 3'h0 : d.perm;
			// hint bits never change the fetch type
			rsp_memtype <= dped_pkg::MEMTYPE_WB;
			last_r      <= {d.gpa, d.rsv, d.np, d.fault};
		end
	end

	// Response strobe, one cycle in the done state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= (st_r == dped_pkg::ST_CHECK && !d.upd) ||
				(st_r == dped_pkg::ST_WB && wb_ready);
		end
	end

	// flag write-back; faulted entries are never written
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_valid <= 1'b0;
			wb_entry <= 64'h0;
		end else if (st_r == dped_pkg::ST_CHECK && d.upd) begin
			wb_valid <= 1'b1;
			wb_entry <= d.wb_entry;
		end else if (wb_ready) begin
			wb_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			walks_r <= 16'h0;
		end else if (st_r == dped_pkg::ST_DONE) begin
			walks_r <= walks_r + 16'h1;
		end
	end

	// Register slave: answer one cycle after the request appears
	assign acc = (avs_read || avs_write) && avs_waitrequest;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !acc;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= dped_pkg::CTRL_RST;
		end else if (avs_write && !avs_waitrequest &&
				avs_address == dped_pkg::OFS_CTRL && avs_byteenable[0]) begin
			ctrl_r <= avs_writedata[dped_pkg::CTRL_W-1:0];
		end
	end

	always_comb begin
		rd_nxt = 32'h0;
		case (avs_address)
			dped_pkg::OFS_CTRL:    rd_nxt = {27'h0, ctrl_r};
			dped_pkg::OFS_STATUS:  rd_nxt = {walks_r, 10'h0, st_r, last_r};
			dped_pkg::OFS_BASE_LO: rd_nxt = rsp_base[31:0];
			dped_pkg::OFS_BASE_HI: rd_nxt = {12'h0, rsp_base[51:32]};
			dped_pkg::OFS_ENT_LO:  rd_nxt = ent_r[31:0];
			dped_pkg::OFS_ENT_HI:  rd_nxt = ent_r[63:32];
			default:               rd_nxt = 32'h0;
		endcase
	end

	// Read data stands through the cycle waitrequest is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (acc && avs_read) begin
			avs_readdata <= rd_nxt;
		end
	end

	a_absent_faults: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && !ent_r[0]) |=> (rsp_valid && rsp_fault && !wb_valid))
		else $error("absent entry not faulted");

	a_reserved_faults: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && (ent_r[7] || ent_r[51])) |=> rsp_fault)
		else $error("reserved bit not faulted");

	a_exec_denied: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && ctrl_r[0] && ent_r[63]) |=> !rsp_perm[2])
		else $error("execute granted under exec disable");

	a_user_denied: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && !ent_r[2]) |=> !rsp_perm[0])
		else $error("user access granted with bit 2 clear");

	a_write_denied: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && !ent_r[1]) |=> !rsp_perm[1])
		else $error("write granted with bit 1 clear");

	a_accessed_set: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && ent_r[0] && !ent_r[5] && !ent_r[7]
			&& ent_r[51:39] == 13'h0) |=> (wb_valid && wb_entry[5]))
		else $error("accessed flag not written back");

	a_ext_kept: assert property (@(posedge clk) disable iff (rst)
		$rose(wb_valid) && !ctrl_r[3] |-> wb_entry[10] == ent_r[10])
		else $error("extended access changed while disabled");

	a_ext_set: assert property (@(posedge clk) disable iff (rst)
		$rose(wb_valid) && ctrl_r[3] |-> wb_entry[10])
		else $error("extended access not set");

	a_base_align: assert property (@(posedge clk) disable iff (rst)
		rsp_valid |-> (rsp_base[11:0] == 12'h0 && rsp_base[51:46] == 6'h0))
		else $error("base misaligned or above width");

	a_nested_gpa: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && ctrl_r[1] && !d.fault) |=> rsp_gpa)
		else $error("nested base not marked guest");

	a_wb_memtype: assert property (@(posedge clk) disable iff (rst)
		rsp_valid |-> rsp_memtype == 3'h6)
		else $error("table fetch type not write-back");

	a_bus_answer: assert property (@(posedge clk) disable iff (rst)
		$rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("bus answer late");

	// One answer per access
	a_bus_single: assert property (@(posedge clk) disable iff (rst)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than a cycle");

	a_sup_as_user: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && sup_r && !ent_r[2]) |=> !rsp_perm[0])
		else $error("supervisor request passed user check");

	a_sup_write: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && sup_r && ctrl_r[2] && !ent_r[1]) |=> !rsp_perm[1])
		else $error("supervisor write granted");

	a_fault_empty: assert property (@(posedge clk) disable iff (rst)
		(rsp_valid && rsp_fault) |-> (rsp_base == 52'h0 && rsp_perm == 3'h0 && !rsp_gpa))
		else $error("faulted result not cleared");

	// no guest flag without nested enable
	a_no_gpa: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && !ctrl_r[1]) |=> !rsp_gpa)
		else $error("guest flag without nested enable");

	a_client_width: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && !ctrl_r[4]) |=> rsp_base[51:39] == 13'h0)
		else $error("base above client width");

	a_base_pass: assert property (@(posedge clk) disable iff (rst)
		(st_r == dped_pkg::ST_CHECK && ent_r[0] && !ent_r[7] && ent_r[51:39] == 13'h0)
			|=> rsp_base == {13'h0, ent_r[38:12], 12'h0})
		else $error("base bits not passed through");

	// ignored bits kept in the write-back
	a_ignored_kept: assert property (@(posedge clk) disable iff (rst)
		$rose(wb_valid) |-> (wb_entry[63:11] == ent_r[63:11] &&
			wb_entry[9:6] == ent_r[9:6] && wb_entry[4:0] == ent_r[4:0]))
		else $error("write-back altered a field");

	// Entries taken only while idle
	a_ready_idle: assert property (@(posedge clk) disable iff (rst)
		req_ready == (st_r == dped_pkg::ST_IDLE))
		else $error("ready out of step with idle");

	// Result strobe lasts one cycle
	a_rsp_pulse: assert property (@(posedge clk) disable iff (rst)
		rsp_valid |=> !rsp_valid)
		else $error("result strobe longer than a cycle");

	// Memory may stall; request must not move meanwhile
	a_wb_held: assert property (@(posedge clk) disable iff (rst)
		(wb_valid && !wb_ready) |=> (wb_valid && $stable(wb_entry)))
		else $error("write-back dropped before acceptance");
endmodule : dped_top
`default_nettype wire

// ==== bench/dped_mem_model.sv ====
// Memory-side model: offers entries and takes write-backs
`timescale 1ns/10ps
`default_nettype none
module dped_mem_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Entry offer
	output var  logic        req_valid,
	input  wire logic        req_ready,
	output var  logic [63:0] req_entry,
	output var  logic        req_sup,
	// Write-back
	input  wire logic        wb_valid,
	output var  logic        wb_ready,
	input  wire logic [63:0] wb_entry
);
	int          stall;
	int          wait_n;

	initial begin
		stall = 0;
		req_valid = 1'b0;
		req_entry = 64'h0;
		req_sup = 1'b0;
	end

	// Call right after an edge; released lines show no stale entry
	task automatic offer(input logic [63:0] e, input logic s);
		int n;
		req_valid <= 1'b1;
		req_entry <= e;
		req_sup <= s;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (req_ready) break;
		end
		req_valid <= 1'b0;
		req_entry <= ~e;
		req_sup <= ~s;
	endtask : offer

	// Accepts a write-back after stall cycles
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ready <= 1'b0;
			wait_n <= 0;
		end else begin
			wb_ready <= wb_valid && !wb_ready && wait_n >= stall;
			wait_n <= (wb_valid && !wb_ready) ? wait_n + 1 : 0;
		end
	end
endmodule : dped_mem_model
`default_nettype wire

// ==== bench/dped_top_tb_top.sv ====
// Self-checking bench of the directory-pointer entry decoder
`timescale 1ns/10ps
`default_nettype none
module dped_top_tb_top;
	logic        clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        req_valid, req_ready, req_sup, rsp_valid, rsp_fault, rsp_gpa;
	logic [63:0] req_entry, wb_entry, e;
	logic [51:0] rsp_base;
	logic [2:0]  rsp_perm, rsp_memtype;
	logic        wb_valid, wb_ready;
	logic [4:0]  ctrl_v;
	logic [59:0] rspq[$];
	logic [63:0] wbq[$];
	logic [31:0] regq[$];
	int          err_total, check_count, walks, i;

	dped_top dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_ready(req_ready),
		.req_entry(req_entry), .req_sup(req_sup), .rsp_valid(rsp_valid),
		.rsp_fault(rsp_fault), .rsp_base(rsp_base), .rsp_gpa(rsp_gpa), .rsp_perm(rsp_perm),
		.rsp_memtype(rsp_memtype), .wb_valid(wb_valid), .wb_ready(wb_ready),
		.wb_entry(wb_entry));
	dped_mem_model mem (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req_entry(req_entry), .req_sup(req_sup), .wb_valid(wb_valid),
		.wb_ready(wb_ready), .wb_entry(wb_entry));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic results();
		$display("Checks %0d, errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	task automatic tally(input string what, input logic [63:0] x, input logic [63:0] got);
		check_count++;
		if (got !== x) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, x, got);
		end
	endtask : tally

	task automatic chk_rsp(input logic [59:0] x, input logic [59:0] g);
		tally("result", {4'h0, x}, {4'h0, g});
	endtask : chk_rsp
	task automatic chk_wb(input logic [63:0] x, input logic [63:0] g);
		tally("write-back", x, g);
	endtask : chk_wb
	task automatic chk_reg(input logic [31:0] x, input logic [31:0] g);
		tally("register", {32'h0, x}, {32'h0, g});
	endtask : chk_reg

	task automatic bail();
		err_total++;
		results();
	endtask : bail

	initial begin
		#(20 * 60000);
		bail();
	end

	// Expected {fault, base, gpa, perm, memtype}; request privilege plays no part
	function automatic logic [59:0] exp_rsp(input logic [63:0] v);
		int aw;
		logic f;
		aw = ctrl_v[4] ? int'(dped_pkg::ADDR_W_SERVER) : int'(dped_pkg::ADDR_W_CLIENT);
		f = !v[0] || v[7] || ((v[51:0] >> aw) != 52'h0);
		return {f, f ? 52'h0 : (v[51:0] & ((52'h1 << aw) - 52'h1) & ~52'hfff),
			ctrl_v[1] && !f, f ? 3'h0 : {!(ctrl_v[0] && v[63]), v[1], v[2]},
			dped_pkg::MEMTYPE_WB};
	endfunction : exp_rsp

	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [31:0] x);
		int n;
		if (!w) regq.push_back(x);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (!avs_waitrequest) break;
		end
		if (n == 50) bail();
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic set_ctrl(input logic [4:0] v);
		bus(1'b1, dped_pkg::OFS_CTRL, {27'h0, v}, 32'h0);
		ctrl_v = v;
		bus(1'b0, dped_pkg::OFS_CTRL, 32'h0, {27'h0, v});
	endtask : set_ctrl

	task automatic walk(input logic [63:0] v);
		logic [59:0] x;
		int n;
		x = exp_rsp(v);
		rspq.push_back(x);
		// write-back only when a flag changes
		if (!x[59] && (!v[5] || (ctrl_v[3] && !v[10])))
			wbq.push_back(v | 64'h20 | (ctrl_v[3] ? 64'h400 : 64'h0));
		walks++;
		mem.stall = $urandom_range(3, 0);
		mem.offer(v, 1'($urandom_range(1, 0)));
		for (n = 0; n < 100 && rspq.size() != 0; n++) @(posedge clk);
		if (rspq.size() != 0) bail();
		@(posedge clk);
	endtask : walk

	always @(posedge clk) begin
		if (rsp_valid)
			chk_rsp(rspq.size() ? rspq.pop_front() : 'x, {rsp_fault, rsp_base, rsp_gpa, rsp_perm, rsp_memtype});
		if (wb_valid && wb_ready)
			chk_wb(wbq.size() ? wbq.pop_front() : 'x, wb_entry);
		if (avs_read && !avs_waitrequest)
			chk_reg(regq.size() ? regq.pop_front() : 'x, avs_readdata);
	end

	initial begin
		void'($urandom(32'h7737));
		{rst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 37'h0};
		avs_byteenable = 4'hf;
		ctrl_v = 5'h10;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, dped_pkg::OFS_CTRL, 32'h0, 32'h10);
		bus(1'b1, 5'h18, 32'hffffffff, 32'h0);
		bus(1'b0, 5'h18, 32'h0, 32'h0);
		// width edges of the server form, ignored bits set, then reserved bit 7 and an absent entry
		walk(64'h0000_4000_0000_1007);
		walk(64'h0000_2000_0000_1007);
		walk(64'h7ff0_0000_0000_0b47);
		walk(64'h0000_0000_0000_0083);
		walk(64'h0000_0000_0000_0002);
		bus(1'b0, dped_pkg::OFS_STATUS, 32'h0, {walks[15:0], 16'h0003});
		set_ctrl(5'h0f);
		walk(64'h0000_0080_0000_0001);
		walk(64'h0000_0040_1234_5001);
		bus(1'b1, dped_pkg::OFS_BASE_LO, 32'hffffffff, 32'h0);
		bus(1'b0, dped_pkg::OFS_BASE_LO, 32'h0, 32'h1234_5000);
		bus(1'b0, dped_pkg::OFS_BASE_HI, 32'h0, 32'h40);
		bus(1'b0, dped_pkg::OFS_ENT_LO, 32'h0, 32'h1234_5001);
		bus(1'b0, dped_pkg::OFS_ENT_HI, 32'h0, 32'h40);
		for (i = 0; i < 128; i++) begin
			if (i % 4 == 0) set_ctrl(5'($urandom));
			e = {$urandom, $urandom};
			// most entries built clean and present
			if (i % 3 != 0)
				e = (e & ~(64'h000f_ffff_ffff_ffff & ~((64'h1 << (ctrl_v[4] ? 46 : 39)) - 64'h1)) & ~64'h80) | 64'h1;
			walk(e);
		end
		tally("pending", 64'h0, 64'(rspq.size() + wbq.size() + regq.size()));
		results();
	end
endmodule : dped_top_tb_top
`default_nettype wire
